// [mcusx_pkg.sv]
// Purpose: shared types and constants of the skip, table and xor unit
// Assumes: 8-bit data path, 15-bit program word address
// Notes: operation codes are local to this unit
package mcusx_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ROM_AW = 15;
    localparam int ROM_DW = 16;
    localparam int PAGE_W = 7;

    // ------------------------------------------------------------
    // Fixed values
    // ------------------------------------------------------------
    localparam logic [PAGE_W-1:0] LAST_PAGE = 7'h7f;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic ZERO_RESET = 1'b0;
    localparam logic [DATA_W-1:0] TBLHI_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

    // ------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------
    localparam int SKIP_CYCLES = 2;
    localparam int PLAIN_CYCLES = 1;
    localparam int TABLE_CYCLES = 2;

    // ------------------------------------------------------------
    // Operations
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR = 4'h1,
        OP_SKIP_ON_ZERO_TEST = 4'h2,
        OP_COPY_AND_SKIP_ON_ZERO = 4'h3,
        OP_SKIP_ON_BIT_ZERO = 4'h4,
        OP_TABLE_READ_CURRENT_PAGE = 4'h5,
        OP_TABLE_READ_FINAL_PAGE = 4'h6,
        OP_XOR_ACC_WITH_MEMORY = 4'h7,
        OP_EXCLUSIVE_OR_INTO_MEMORY = 4'h8,
        OP_XOR_ACC_WITH_IMMEDIATE = 4'h9
    } mcusx_op_e;

    typedef enum logic [1:0] {
        ST_EXEC = 2'b00,
        ST_DUMMY = 2'b01,
        ST_TABLE = 2'b10
    } mcusx_state_e;

endpackage

// [mcusx_exec_if.sv]
// Purpose: carries operands to and results from the operation decoder
// Assumes: one clock domain, purely combinational results
// Notes: none
`timescale 1ns/100ps
interface mcusx_exec_if;
    import mcusx_pkg::*;

    mcusx_op_e op;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] mem_rd;
    logic [2:0] bit_sel;
    logic [DATA_W-1:0] imm;

    logic acc_we;
    logic [DATA_W-1:0] acc_val;
    logic mem_we;
    logic [DATA_W-1:0] mem_val;
    logic zero_we;
    logic zero_val;
    logic skip;
    logic table_rd;
    logic final_page;

    modport ctrl (
        output op, acc, mem_rd, bit_sel, imm,
        input acc_we, acc_val, mem_we, mem_val, zero_we, zero_val,
        input skip, table_rd, final_page
    );
    modport dec (
        input op, acc, mem_rd, bit_sel, imm,
        output acc_we, acc_val, mem_we, mem_val, zero_we, zero_val,
        output skip, table_rd, final_page
    );
endinterface

// [mcusx_op_decode.sv]
// Purpose: decodes one operation into its result and side effects
// Assumes: operand byte is valid in the same cycle as the operation
// Notes: purely combinational
`timescale 1ns/100ps
module mcusx_op_decode
    import mcusx_pkg::*;
(
    // Operation in, results out
    mcusx_exec_if.dec x
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return (v == ZERO_BYTE);
    endfunction

    logic [DATA_W-1:0] xor_mem;
    logic [DATA_W-1:0] xor_imm;

    assign xor_mem = x.acc ^ x.mem_rd;
    assign xor_imm = x.acc ^ x.imm;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    always_comb begin
        x.acc_we = 1'b0;
        x.acc_val = x.acc;
        x.mem_we = 1'b0;
        x.mem_val = x.mem_rd;
        x.zero_we = 1'b0;
        x.zero_val = 1'b0;
        x.skip = 1'b0;
        x.table_rd = 1'b0;
        x.final_page = 1'b0;
        unique case (x.op)
            OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR: begin
                x.acc_we = 1'b1;
                x.acc_val = {x.mem_rd[3:0], x.mem_rd[7:4]};
            end
            OP_SKIP_ON_ZERO_TEST: begin
                x.skip = is_zero(x.mem_rd);
            end
            OP_COPY_AND_SKIP_ON_ZERO: begin
                x.acc_we = 1'b1;
                x.acc_val = x.mem_rd;
                x.skip = is_zero(x.mem_rd);
            end
            OP_SKIP_ON_BIT_ZERO: begin
                x.skip = ~x.mem_rd[x.bit_sel];
            end
            OP_TABLE_READ_CURRENT_PAGE: begin
                x.table_rd = 1'b1;
            end
            OP_TABLE_READ_FINAL_PAGE: begin
                x.table_rd = 1'b1;
                x.final_page = 1'b1;
            end
            OP_XOR_ACC_WITH_MEMORY: begin
                x.acc_we = 1'b1;
                x.acc_val = xor_mem;
                x.zero_we = 1'b1;
                x.zero_val = is_zero(xor_mem);
            end
            OP_EXCLUSIVE_OR_INTO_MEMORY: begin
                x.mem_we = 1'b1;
                x.mem_val = xor_mem;
                x.zero_we = 1'b1;
                x.zero_val = is_zero(xor_mem);
            end
            OP_XOR_ACC_WITH_IMMEDIATE: begin
                x.acc_we = 1'b1;
                x.acc_val = xor_imm;
                x.zero_we = 1'b1;
                x.zero_val = is_zero(xor_imm);
            end
            default: begin
            end
        endcase
    end

endmodule // mcusx_op_decode

// [mcusx_exec_unit.sv]
// Purpose: executes skip, table read, nibble exchange and xor operations
// Assumes: core presents operand byte with the operation, same clock
// Notes: ROM data is sampled one cycle after the ROM request
//
// Contract
// - Nibble exchange writes memory byte halves swapped into accumulator only.
// - On skip, drop the prefetched word and insert one dummy cycle.
// - Byte zero test skips when byte is zero, no flag change.
// - Copy byte to accumulator, skip if zero, flags untouched.
// - Selected bit zero skips next instruction, flags untouched.
// - Current page table read: low byte to memory, high to latch.
// - Final page table read: low byte to memory, high to latch.
// - Accumulator gets accumulator xor memory byte, only zero flag.
// - Memory byte gets accumulator xor memory, accumulator kept.
// - Accumulator gets accumulator xor immediate, only zero flag.
`timescale 1ns/100ps
module mcusx_exec_unit
    import mcusx_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Operation issue
    input wire logic instr_valid,
    input wire logic [3:0] instr_op,
    input wire logic [DATA_W-1:0] instr_addr,
    input wire logic [2:0] instr_bit,
    input wire logic [DATA_W-1:0] instr_imm,
    input wire logic [DATA_W-1:0] mem_rdata,
    output logic instr_ready,
    // Fetch control
    output logic prefetch_discard,
    output logic dummy_cycle,
    output logic op_done,
    // Core context
    input wire logic [ROM_AW-1:0] pc_now,
    input wire logic [DATA_W-1:0] rom_table_pointer,
    // Program memory read
    output logic rom_req,
    output logic [ROM_AW-1:0] rom_addr,
    input wire logic [ROM_DW-1:0] rom_rdata,
    // Data memory write
    output logic mem_we,
    output logic [DATA_W-1:0] mem_waddr,
    output logic [DATA_W-1:0] mem_wdata,
    // Architectural state
    output logic [DATA_W-1:0] working_accumulator,
    output logic zero_flag,
    output logic [DATA_W-1:0] table_high_byte_latch
);

    // ------------------------------------------------------------
    // Decoder
    // ------------------------------------------------------------
    mcusx_exec_if x ();

    mcusx_state_e state;
    mcusx_state_e next_state;
    logic take;
    logic [DATA_W-1:0] table_dest;

    // Unused codes act as no operation
    function automatic logic is_known_op(input logic [3:0] code);
        return (code >= OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR)
            && (code <= OP_XOR_ACC_WITH_IMMEDIATE);
    endfunction

    assign take = instr_valid && (state == ST_EXEC);
    assign x.op = (take && is_known_op(instr_op)) ? mcusx_op_e'(instr_op)
        : OP_NONE;
    assign x.acc = working_accumulator;
    assign x.mem_rd = mem_rdata;
    assign x.bit_sel = instr_bit;
    assign x.imm = instr_imm;

    mcusx_op_decode u_dec (
        .x (x.dec)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            ST_EXEC: begin
                if (x.skip) begin
                    next_state = ST_DUMMY;
                end else if (x.table_rd) begin
                    next_state = ST_TABLE;
                end
            end
            ST_DUMMY: begin
                next_state = ST_EXEC;
            end
            ST_TABLE: begin
                next_state = ST_EXEC;
            end
            default: begin
                next_state = ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= ST_EXEC;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            instr_ready <= 1'b1;
        end else begin
            instr_ready <= (next_state == ST_EXEC);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prefetch_discard <= 1'b0;
        end else begin
            prefetch_discard <= take && x.skip;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dummy_cycle <= 1'b0;
        end else begin
            dummy_cycle <= (next_state == ST_DUMMY);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            op_done <= 1'b0;
        end else begin
            op_done <= (take && !x.table_rd && x.op != OP_NONE)
                || (state == ST_TABLE);
        end
    end

    // ------------------------------------------------------------
    // Program memory request
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rom_req <= 1'b0;
            rom_addr <= '0;
            table_dest <= '0;
        end else begin
            rom_req <= take && x.table_rd;
            if (take && x.table_rd) begin
                table_dest <= instr_addr;
                if (x.final_page) begin
                    rom_addr <= {LAST_PAGE, rom_table_pointer};
                end else begin
                    rom_addr <= {pc_now[ROM_AW-1:DATA_W], rom_table_pointer};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Data memory write
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mem_we <= 1'b0;
            mem_waddr <= '0;
            mem_wdata <= '0;
        end else begin
            mem_we <= 1'b0;
            if (state == ST_TABLE) begin
                mem_we <= 1'b1;
                mem_waddr <= table_dest;
                mem_wdata <= rom_rdata[DATA_W-1:0];
            end else if (x.mem_we) begin
                mem_we <= 1'b1;
                mem_waddr <= instr_addr;
                mem_wdata <= x.mem_val;
            end
        end
    end

    // ------------------------------------------------------------
    // Accumulator, zero flag, table latch
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            working_accumulator <= ACC_RESET;
        end else if (x.acc_we) begin
            working_accumulator <= x.acc_val;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            zero_flag <= ZERO_RESET;
        end else if (x.zero_we) begin
            zero_flag <= x.zero_val;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            table_high_byte_latch <= TBLHI_RESET;
        end else if (state == ST_TABLE) begin
            table_high_byte_latch <= rom_rdata[ROM_DW-1:DATA_W];
        end
    end

endmodule // mcusx_exec_unit

// [mcusx_exec_checker.sv]
// Purpose: assertions on the skip, table and xor unit
// Assumes: one clock, asynchronous active-high reset
// Notes: bound to every instance of the unit
`timescale 1ns/100ps
module mcusx_exec_checker
    import mcusx_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Issue
    input wire logic instr_valid,
    input wire logic [3:0] instr_op,
    input wire logic [2:0] instr_bit,
    input wire logic [DATA_W-1:0] mem_rdata,
    input wire logic [DATA_W-1:0] rom_table_pointer,
    // Results
    input wire logic instr_ready,
    input wire logic prefetch_discard,
    input wire logic dummy_cycle,
    input wire logic rom_req,
    input wire logic [ROM_AW-1:0] rom_addr,
    input wire logic mem_we,
    input wire logic [DATA_W-1:0] mem_wdata,
    input wire logic [DATA_W-1:0] working_accumulator,
    input wire logic zero_flag
);
    default clocking
        @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    logic take;
    logic bit_zero;
    assign take = instr_valid && instr_ready;
    assign bit_zero = !mem_rdata[instr_bit];

    property p_byte_skip;
        take && instr_op == 4'h2 && mem_rdata == ZERO_BYTE |=>
            prefetch_discard && dummy_cycle && !instr_ready;
    endproperty
    a_byte_skip: assert property (p_byte_skip)
        else $error("zero byte test did not skip");

    property p_no_skip;
        take && instr_op == 4'h2 && mem_rdata != ZERO_BYTE |=>
            !prefetch_discard && instr_ready;
    endproperty
    a_no_skip: assert property (p_no_skip)
        else $error("nonzero byte test skipped");

    property p_dummy_once;
        prefetch_discard |=> !dummy_cycle && instr_ready;
    endproperty
    a_dummy_once: assert property (p_dummy_once)
        else $error("dummy cycle longer than one cycle");

    property p_bit_skip;
        take && instr_op == 4'h4 |=> prefetch_discard == $past(bit_zero);
    endproperty
    a_bit_skip: assert property (p_bit_skip)
        else $error("bit test skip wrong");

    property p_copy;
        take && instr_op == 4'h3 |=> working_accumulator == $past(mem_rdata)
            && $stable(zero_flag);
    endproperty
    a_copy: assert property (p_copy)
        else $error("copy and test result wrong");

    property p_nibble;
        take && instr_op == 4'h1 |=>
            {working_accumulator[3:0], working_accumulator[7:4]}
            == $past(mem_rdata) && !mem_we;
    endproperty
    a_nibble: assert property (p_nibble)
        else $error("nibble exchange wrong");

    property p_xor_mem;
        take && instr_op == 4'h8 |=> mem_we && $stable(working_accumulator)
            && mem_wdata == ($past(working_accumulator) ^ $past(mem_rdata));
    endproperty
    a_xor_mem: assert property (p_xor_mem)
        else $error("xor into memory wrong");

    property p_xor_zero;
        take && (instr_op == 4'h7 || instr_op == 4'h9) |=>
            zero_flag == (working_accumulator == ZERO_BYTE);
    endproperty
    a_xor_zero: assert property (p_xor_zero)
        else $error("xor zero flag wrong");

    property p_final_page;
        take && instr_op == 4'h6 |=> rom_req
            && rom_addr == {LAST_PAGE, $past(rom_table_pointer)}
            ##1 mem_we && !rom_req;
    endproperty
    a_final_page: assert property (p_final_page)
        else $error("final page table read wrong");
endmodule // mcusx_exec_checker

bind mcusx_exec_unit mcusx_exec_checker mcusx_exec_checker_i (
    .clk_sys, .rst, .instr_valid, .instr_op, .instr_bit, .mem_rdata,
    .rom_table_pointer, .instr_ready, .prefetch_discard, .dummy_cycle,
    .rom_req, .rom_addr, .mem_we, .mem_wdata, .working_accumulator,
    .zero_flag
);

// [mcusx_tb.sv]
// Purpose: self-checking bench of the skip, table and xor unit
// Assumes: 25 MHz clock, reset held ten cycles
// Notes: one task per scenario
`timescale 1ns/100ps
module testbench
    import mcusx_pkg::*;
;
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    err_count++; $display("wrong value %s exp %h got %h", n, e, g); end end
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic instr_valid = 1'b0;
    logic [3:0] instr_op = 4'h0;
    logic [7:0] instr_addr = 8'h00;
    logic [2:0] instr_bit = 3'h0;
    logic [7:0] instr_imm = 8'h00;
    logic [7:0] mem_rdata = 8'h00;
    logic [14:0] pc_now = 15'h0000;
    logic [7:0] ptr = 8'h00;
    logic [15:0] rom_rdata = 16'h0000;
    logic rdy, disc, dummy, done, rreq, we, zf;
    logic [14:0] raddr;
    logic [7:0] waddr, wdata, acc, latch;
    int err_count = 0;
    int comparisons = 0;

    always #20 clk_sys = ~clk_sys;

    mcusx_exec_unit mcusx_exec_unit_i (
        .clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid),
        .instr_op(instr_op), .instr_addr(instr_addr),
        .instr_bit(instr_bit), .instr_imm(instr_imm),
        .mem_rdata(mem_rdata), .instr_ready(rdy),
        .prefetch_discard(disc), .dummy_cycle(dummy), .op_done(done),
        .pc_now(pc_now), .rom_table_pointer(ptr), .rom_req(rreq),
        .rom_addr(raddr), .rom_rdata(rom_rdata), .mem_we(we),
        .mem_waddr(waddr), .mem_wdata(wdata), .working_accumulator(acc),
        .zero_flag(zf), .table_high_byte_latch(latch)
    );

    task automatic issue(input logic [3:0] op, input logic [7:0] m,
        input logic [2:0] b, input logic [7:0] imm);
        @(posedge clk_sys);
        instr_valid <= 1'b1;
        instr_op <= op;
        mem_rdata <= m;
        instr_bit <= b;
        instr_imm <= imm;
        instr_addr <= imm;
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        #1;
    endtask

    task automatic t_xor();
        issue(4'h1, 8'h3c, 3'h0, 8'h00);
        `CHK("acc", 8'hc3, acc)
        `CHK("done", 1'b1, done)
        `CHK("we", 1'b0, we)
        issue(4'h7, 8'hc3, 3'h0, 8'h00);
        `CHK("acc", 8'h00, acc)
        `CHK("zero", 1'b1, zf)
        issue(4'h9, 8'h00, 3'h0, 8'h5a);
        `CHK("acc", 8'h5a, acc)
        `CHK("zero", 1'b0, zf)
        issue(4'h8, 8'h5a, 3'h0, 8'h33);
        `CHK("we", 1'b1, we)
        `CHK("waddr", 8'h33, waddr)
        `CHK("wdata", 8'h00, wdata)
        `CHK("acc", 8'h5a, acc)
        `CHK("zero", 1'b1, zf)
        issue(4'hf, 8'hff, 3'h0, 8'h00);
        `CHK("done", 1'b0, done)
        `CHK("we", 1'b0, we)
        `CHK("acc", 8'h5a, acc)
        `CHK("zero", 1'b1, zf)
    endtask

    task automatic t_skips();
        logic [3:0] ops [6] = '{4'h2, 4'h2, 4'h3, 4'h3, 4'h4, 4'h4};
        logic [7:0] ms [6] = '{8'h00, 8'h01, 8'h00, 8'h80, 8'hdf, 8'h20};
        for (int i = 0; i < 6; i++) begin
            issue(ops[i], ms[i], 3'h5, 8'h10);
            `CHK("discard", i % 2 == 0, disc)
            `CHK("dummy", i % 2 == 0, dummy)
            `CHK("ready", i % 2 != 0, rdy)
            `CHK("done", 1'b1, done)
            `CHK("zero", 1'b1, zf)
            if (ops[i] == 4'h3) `CHK("acc", ms[i], acc)
            @(posedge clk_sys);
            #1;
            `CHK("dummy", 1'b0, dummy)
            `CHK("done", 1'b0, done)
        end
    endtask

    task automatic t_table();
        for (int j = 0; j < 2; j++) begin
            @(posedge clk_sys);
            pc_now <= j ? 15'h7a00 : 15'h1234;
            ptr <= j ? 8'h9b : 8'h56;
            rom_rdata <= j ? 16'h00ff : 16'hbeef;
            issue(j ? 4'h6 : 4'h5, 8'hff, 3'h0, 8'h44);
            `CHK("rreq", 1'b1, rreq)
            `CHK("raddr", j ? {LAST_PAGE, 8'h9b} : 15'h1256, raddr)
            `CHK("done", 1'b0, done)
            `CHK("ready", 1'b0, rdy)
            @(posedge clk_sys);
            #1;
            `CHK("we", 1'b1, we)
            `CHK("done", 1'b1, done)
            `CHK("rreq", 1'b0, rreq)
            `CHK("waddr", 8'h44, waddr)
            `CHK("wdata", j ? 8'hff : 8'hef, wdata)
            `CHK("latch", j ? 8'h00 : 8'hbe, latch)
            `CHK("zero", 1'b1, zf)
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #(40 * 1000);
        err_count++;
        finish_test();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        `CHK("acc", 8'h00, acc)
        `CHK("ready", 1'b1, rdy)
        t_xor();
        t_skips();
        t_table();
        finish_test();
    end
endmodule // testbench
